// *** shared/rcru_pkg.sv ***
/*
  Constants for the relative call and subroutine return unit: opcode
  patterns, address and stack word widths, stack memory size.
  Assumes the core presents whole instructions and owns all other opcodes.
*/
package rcru_pkg;

  localparam int unsigned PC_W = 17;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned STACK_W = 9;
  localparam int unsigned RAM_AW = 8;
  localparam int unsigned RAM_DEPTH = 256;
  localparam int unsigned OFFSET_W = 12;

  // Byte 0 of the offset call is 010x1yyy
  localparam logic [7:0] OFFSET_CALL_MASK = 8'he8;
  localparam logic [7:0] OFFSET_CALL_MATCH = 8'h48;
  localparam int unsigned OFFSET_HI_BIT = 4;
  localparam logic [7:0] ACC_CALL_OPCODE = 8'h10;
  localparam logic [7:0] RETURN_OPCODE = 8'ha0;

  localparam logic [15:0] OFFSET_CALL_LEN = 16'h0002;
  localparam logic [15:0] ACC_CALL_LEN = 16'h0001;
  localparam logic [15:0] SP_STEP = 16'h0001;

  localparam int unsigned STACK_FLAG_BIT = 8;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_OFFSET_CALL,
    OP_ACC_CALL,
    OP_RETURN
  } rcru_op_e;

endpackage

// *** hw/rcru_stack_ram.sv ***
/*
  Stack memory of 9-bit words: one write port and two read ports whose
  data come out of registers one clock after the address.
  Assumes a single clock; contents are undefined after power-up.
*/
`timescale 1ns/100ps
module rcru_stack_ram
  import rcru_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [RAM_AW-1:0] wr_addr,
  input wire logic [STACK_W-1:0] wr_data,
  input wire logic [RAM_AW-1:0] rd_addr_a,
  input wire logic [RAM_AW-1:0] rd_addr_b,
  output logic [STACK_W-1:0] rd_data_a,
  output logic [STACK_W-1:0] rd_data_b
);

  logic [STACK_W-1:0] mem [RAM_DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk)
  begin
    rd_data_a <= mem[rd_addr_a];
    rd_data_b <= mem[rd_addr_b];
  end

endmodule

// *** hw/rcru_unit.sv ***
/*
  Relative call and subroutine return execution: decodes the offset call,
  the accumulator-relative call and the subroutine return, pushes or pops
  the 9-bit-per-byte return word in stack memory, and hands back the new
  program counter, stack pointer and bank flag.
  Assumes the core offers one instruction at a time on instr_valid, waits
  for instr_ready, and takes the results when exec_done pulses.
*/
// Functional notes
// RULE1: Offset call is two bytes, 010x1yyy then low offset byte.
// RULE2: Offset call target is current address plus two plus offset.
// RULE3: Offset call bumps pointer, writes return word, bumps pointer again.
// RULE4: Stacked high byte bit 8 holds PC bit 16, low byte bank flag.
// RULE5: Opcode 10H is a one-byte accumulator call, return address plus one.
// RULE6: Accumulator call adds unsigned accumulator to next instruction address.
// RULE7: Accumulator call bumps pointer, writes word, bumps pointer, then branches.
// RULE8: Opcode A0H returns, loading PC from stacked word.
// RULE9: Return drops pointer, reads word, drops pointer again.
// RULE10: Return restores bank flag and PC bit 16 from stacked bit 8.
// RULE11: Low return byte goes after first increment, high after second.
// RULE12: Each of the three instructions takes two machine cycles.
`timescale 1ns/100ps
module rcru_unit
  import rcru_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [BYTE_W-1:0] instr_opcode,
  input wire logic [BYTE_W-1:0] instr_operand,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [BYTE_W-1:0] acc_in,
  input wire logic bank_in,
  input wire logic [ADDR_W-1:0] sp_in,
  output logic instr_ready,
  output logic instr_claimed,
  output logic exec_done,
  output logic [PC_W-1:0] pc_out,
  output logic [ADDR_W-1:0] sp_out,
  output logic bank_out
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic rcru_op_e rcru_decode(input logic [7:0] opcode);
    rcru_op_e op;
    op = OP_NONE;
    if ((opcode & OFFSET_CALL_MASK) == OFFSET_CALL_MATCH)
    begin
      op = OP_OFFSET_CALL;
    end
    else if (opcode == ACC_CALL_OPCODE)
    begin
      op = OP_ACC_CALL;
    end
    else if (opcode == RETURN_OPCODE)
    begin
      op = OP_RETURN;
    end
    return op;
  endfunction

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CALL2,
    ST_RET2
  } rcru_state_e;

  rcru_state_e state_reg;
  rcru_op_e in_op;
  logic accept;
  logic [OFFSET_W-1:0] call_offset;
  logic [ADDR_W-1:0] offset_ext;
  logic [ADDR_W-1:0] ret_addr;
  logic [ADDR_W-1:0] target_next;
  logic [ADDR_W-1:0] target_reg;
  logic [STACK_W-1:0] high_word_reg;
  logic [ADDR_W-1:0] sp_base_reg;
  logic pc16_reg;
  logic bank_hold_reg;

  assign in_op = rcru_decode(instr_opcode);
  assign instr_claimed = in_op != OP_NONE;
  assign instr_ready = state_reg == ST_IDLE;
  assign accept = instr_valid && instr_ready && instr_claimed;

  // Offset bit 11 sits at opcode bit 4, bits 10..8 at opcode bits 2..0
  assign call_offset = {instr_opcode[OFFSET_HI_BIT], instr_opcode[2:0], instr_operand}; // RULE1
  assign offset_ext = {{(ADDR_W-OFFSET_W){call_offset[OFFSET_W-1]}}, call_offset};

  always_comb
  begin
    ret_addr = pc_in[ADDR_W-1:0] + ACC_CALL_LEN; // RULE5
    target_next = ret_addr + {8'h00, acc_in}; // RULE6
    if (in_op == OP_OFFSET_CALL)
    begin
      ret_addr = pc_in[ADDR_W-1:0] + OFFSET_CALL_LEN; // RULE2
      target_next = ret_addr + offset_ext; // RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (accept && in_op == OP_RETURN)
          begin
            state_reg <= ST_RET2; // RULE8
          end
          else if (accept)
          begin
            state_reg <= ST_CALL2; // RULE1
          end
        end
        ST_CALL2: state_reg <= ST_IDLE; // RULE12
        ST_RET2: state_reg <= ST_IDLE; // RULE12
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Values carried from the first cycle into the second
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      target_reg <= 16'h0000;
      high_word_reg <= 9'h000;
      sp_base_reg <= 16'h0000;
      pc16_reg <= 1'b0;
      bank_hold_reg <= 1'b0;
    end
    else if (accept)
    begin
      target_reg <= target_next;
      high_word_reg <= {pc_in[PC_W-1], ret_addr[15:8]}; // RULE4
      sp_base_reg <= sp_in;
      pc16_reg <= pc_in[PC_W-1];
      bank_hold_reg <= bank_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack memory

  logic ram_we;
  logic [RAM_AW-1:0] ram_waddr;
  logic [STACK_W-1:0] ram_wdata;
  logic [RAM_AW-1:0] ram_raddr_hi;
  logic [RAM_AW-1:0] ram_raddr_lo;
  logic [STACK_W-1:0] ram_rdata_hi;
  logic [STACK_W-1:0] ram_rdata_lo;
  logic [ADDR_W-1:0] sp_plus1;
  logic [ADDR_W-1:0] sp_plus2;
  logic [ADDR_W-1:0] sp_minus1;

  assign sp_plus1 = sp_in + SP_STEP; // RULE3
  assign sp_plus2 = sp_base_reg + SP_STEP + SP_STEP; // RULE7
  assign sp_minus1 = sp_in - SP_STEP; // RULE9

  always_comb
  begin
    ram_we = 1'b0;
    ram_waddr = sp_plus1[RAM_AW-1:0];
    ram_wdata = {bank_in, ret_addr[7:0]};
    if (accept && in_op != OP_RETURN)
    begin
      // Low byte with bank flag, after the first increment
      ram_we = 1'b1; // RULE11
    end
    else if (state_reg == ST_CALL2)
    begin
      // High byte with PC bit 16, after the second increment
      ram_we = 1'b1; // RULE11
      ram_waddr = sp_plus2[RAM_AW-1:0];
      ram_wdata = high_word_reg; // RULE4
    end
  end

  // Pointer names the high byte; the low byte sits one below
  assign ram_raddr_hi = sp_in[RAM_AW-1:0]; // RULE9
  assign ram_raddr_lo = sp_minus1[RAM_AW-1:0]; // RULE9

  rcru_stack_ram u_stack_ram (
    .clk(clk),
    .wr_en(ram_we),
    .wr_addr(ram_waddr),
    .wr_data(ram_wdata),
    .rd_addr_a(ram_raddr_hi),
    .rd_addr_b(ram_raddr_lo),
    .rd_data_a(ram_rdata_hi),
    .rd_data_b(ram_rdata_lo)
  );

  ////////////////////////////////////////////////////////////////////////
  // Results

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exec_done <= 1'b0;
    end
    else
    begin
      exec_done <= state_reg == ST_CALL2 || state_reg == ST_RET2; // RULE12
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pc_out <= 17'h00000;
      sp_out <= 16'h0000;
      bank_out <= 1'b0;
    end
    else if (state_reg == ST_CALL2)
    begin
      pc_out <= {pc16_reg, target_reg}; // RULE2
      sp_out <= sp_plus2; // RULE3
      bank_out <= bank_hold_reg;
    end
    else if (state_reg == ST_RET2)
    begin
      pc_out <= {ram_rdata_hi[STACK_FLAG_BIT], ram_rdata_hi[7:0], ram_rdata_lo[7:0]}; // RULE10
      sp_out <= sp_base_reg - SP_STEP - SP_STEP; // RULE9
      bank_out <= ram_rdata_lo[STACK_FLAG_BIT]; // RULE10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic [ADDR_W-1:0] chk_ret;
  assign chk_ret = pc_in[ADDR_W-1:0] + OFFSET_CALL_LEN;

  a_offset_decode: assert property (@(posedge clk) disable iff (!arst_n) // RULE1
    (instr_valid && instr_ready && ((instr_opcode & 8'he8) == 8'h48)) |=> state_reg == ST_CALL2)
    else $error("offset call opcode not taken");

  a_offset_target: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
    (accept && in_op == OP_OFFSET_CALL) |-> ##2
    pc_out[15:0] == $past(chk_ret, 2) + $past(offset_ext, 2) && pc_out[16] == $past(pc_in[16], 2))
    else $error("offset call target wrong");

  a_call_low_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
    (accept && in_op != OP_RETURN) |->
    ram_we && ram_waddr == sp_in[7:0] + 8'h01 && ram_wdata[8] == bank_in)
    else $error("low return byte misplaced");

  a_call_high_write: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
    (accept && in_op != OP_RETURN) |=>
    ram_we && ram_waddr == $past(sp_in[7:0]) + 8'h02 && ram_wdata[8] == $past(pc_in[16]))
    else $error("high return byte misplaced");

  a_call_sp_step: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
    (accept && in_op != OP_RETURN) |-> ##2 sp_out == $past(sp_in, 2) + 16'h0002)
    else $error("call pointer not raised by two");

  a_acc_target: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
    (accept && in_op == OP_ACC_CALL) |-> ##2
    pc_out[15:0] == $past(pc_in[15:0], 2) + 16'h0001 + {8'h00, $past(acc_in, 2)})
    else $error("accumulator call target wrong");

  a_acc_ret_word: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
    (accept && in_op == OP_ACC_CALL) |-> ram_wdata[7:0] == pc_in[7:0] + 8'h01)
    else $error("accumulator call return address wrong");

  a_ret_sp_step: assert property (@(posedge clk) disable iff (!arst_n) // RULE9
    (accept && in_op == OP_RETURN) |-> ##2 sp_out == $past(sp_in, 2) - 16'h0002 && exec_done)
    else $error("return pointer not lowered by two");

  a_ret_flags: assert property (@(posedge clk) disable iff (!arst_n) // RULE10
    (state_reg == ST_RET2) |=>
    bank_out == $past(ram_rdata_lo[8]) && pc_out[16] == $past(ram_rdata_hi[8]))
    else $error("return flags not restored");

  a_two_cycles: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
    accept |=> !instr_ready ##1 (instr_ready && exec_done))
    else $error("instruction not done in two cycles");

  c_offset_call: cover property (@(posedge clk) disable iff (!arst_n)
    accept && in_op == OP_OFFSET_CALL);
  c_acc_call: cover property (@(posedge clk) disable iff (!arst_n)
    accept && in_op == OP_ACC_CALL);
  c_call_then_return: cover property (@(posedge clk) disable iff (!arst_n)
    (state_reg == ST_CALL2) ##[1:20] (accept && in_op == OP_RETURN));

endmodule

// *** sim/tb_top.sv ***
/*
  Self-checking bench for the relative call and subroutine return unit.
  Assumes the unit's own assertions are live and that results settle
  one cycle after the edge that follows acceptance.
*/
`timescale 1ns/100ps
module tb_top
  import rcru_pkg::*;
;
  logic clk;
  logic arst_n;
  logic instr_valid;
  logic bank_in;
  logic [BYTE_W-1:0] instr_opcode;
  logic [BYTE_W-1:0] instr_operand;
  logic [BYTE_W-1:0] acc_in;
  logic [PC_W-1:0] pc_in;
  logic [ADDR_W-1:0] sp_in;
  logic instr_ready;
  logic instr_claimed;
  logic exec_done;
  logic bank_out;
  logic [PC_W-1:0] pc_out;
  logic [ADDR_W-1:0] sp_out;
  int n_fail;
  int samples_checked;
  int cycles;

  rcru_unit dut (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid),
    .instr_opcode(instr_opcode), .instr_operand(instr_operand), .pc_in(pc_in),
    .acc_in(acc_in), .bank_in(bank_in), .sp_in(sp_in), .instr_ready(instr_ready),
    .instr_claimed(instr_claimed), .exec_done(exec_done), .pc_out(pc_out),
    .sp_out(sp_out), .bank_out(bank_out));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Hang guard, far above the fewer than a hundred cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Entered at a falling edge; leaves at the falling edge of the done cycle
  task automatic run_op(input logic [7:0] op, input logic [7:0] opnd,
    input logic [16:0] pc, input logic [7:0] acc, input logic bank,
    input logic [15:0] sp, input logic [16:0] epc, input logic [15:0] esp,
    input logic exp_bank);
    instr_valid = 1'b1;
    instr_opcode = op;
    instr_operand = opnd;
    pc_in = pc;
    acc_in = acc;
    bank_in = bank;
    sp_in = sp;
    #1;
    check(32'(instr_claimed), 32'h0000_0001);
    check(32'(instr_ready), 32'h0000_0001);
    @(negedge clk);
    // Still offered while busy, with scrambled operands: nothing may be taken
    pc_in = ~pc;
    sp_in = ~sp;
    bank_in = ~bank;
    acc_in = ~acc;
    instr_operand = ~opnd;
    check(32'(instr_ready), 32'h0000_0000);
    check(32'(exec_done), 32'h0000_0000);
    @(negedge clk);
    check(32'(exec_done), 32'h0000_0001);
    check(32'(instr_ready), 32'h0000_0001);
    check(32'(pc_out), 32'(epc));
    check(32'(sp_out), 32'(esp));
    if (op == RETURN_OPCODE)
    begin
      check(32'(bank_out), 32'(exp_bank));
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    check(32'(pc_out), 32'h0000_0000);
    check(32'(sp_out), 32'h0000_0000);
    check(32'({exec_done, instr_ready}), 32'h0000_0001);
  endtask

  // Back-to-back call and return, then the same with bank clear
  task automatic t_offset_call;
    run_op(8'h49, 8'h01, 17'h00ffd, 8'h00, 1'b1, 16'h001f, 17'h01100, 16'h0021, 1'b0);
    run_op(8'ha0, 8'h00, 17'h01102, 8'h00, 1'b0, 16'h0021, 17'h00fff, 16'h001f, 1'b1);
    run_op(8'h49, 8'h00, 17'h00ffe, 8'h00, 1'b0, 16'h001f, 17'h01100, 16'h0021, 1'b0);
    run_op(8'ha0, 8'h00, 17'h01102, 8'h00, 1'b1, 16'h0021, 17'h01000, 16'h001f, 1'b0);
  endtask

  // Every opcode of the offset call, offset high bits from the opcode
  task automatic t_offset_all;
    logic [11:0] off;
    logic [15:0] tgt;
    for (int i = 0; i < 16; i++)
    begin
      off = {i[3], i[2:0], 8'h10};
      tgt = 16'h2002 + {{4{off[11]}}, off};
      run_op({3'b010, i[3], 1'b1, i[2:0]}, 8'h10, 17'h02000, 8'h00, 1'b0,
        16'h0040, {1'b0, tgt}, 16'h0042, 1'b0);
    end
  endtask

  // PC bit 16 and bank flag round trip across a stack address wrap
  task automatic t_pc16_wrap;
    run_op(8'h5f, 8'hff, 17'h1ffff, 8'h00, 1'b1, 16'h00ff, 17'h10000, 16'h0101, 1'b0);
    run_op(8'ha0, 8'h00, 17'h00000, 8'h00, 1'b0, 16'h0101, 17'h10001, 16'h00ff, 1'b1);
  endtask

  task automatic t_acc_call;
    run_op(ACC_CALL_OPCODE, 8'h00, 17'h00ffe, 8'h81, 1'b1, 16'h001f, 17'h01080, 16'h0021, 1'b0);
    run_op(RETURN_OPCODE, 8'h00, 17'h01082, 8'h00, 1'b0, 16'h0021, 17'h00fff, 16'h001f, 1'b1);
    run_op(ACC_CALL_OPCODE, 8'h00, 17'h10000, 8'hff, 1'b0, 16'h0010, 17'h10100, 16'h0012, 1'b0);
    run_op(RETURN_OPCODE, 8'h00, 17'h00000, 8'h00, 1'b1, 16'h0012, 17'h10001, 16'h0010, 1'b0);
  endtask

  // Unclaimed opcodes are offered and must leave everything alone
  task automatic t_refuse;
    logic [7:0] ops [6] = '{8'h40, 8'h50, 8'h47, 8'h11, 8'ha1, 8'hb0};
    foreach (ops[k])
    begin
      instr_valid = 1'b1;
      instr_opcode = ops[k];
      sp_in = 16'h0077;
      #1;
      check(32'(instr_claimed), 32'h0000_0000);
      repeat (3)
      begin
        @(negedge clk);
        check(32'(exec_done), 32'h0000_0000);
        check(32'(instr_ready), 32'h0000_0001);
      end
      check(32'(sp_out), 32'h0000_0010);
    end
    instr_valid = 1'b0;
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    instr_valid = 1'b0;
    instr_opcode = 8'h00;
    instr_operand = 8'h00;
    pc_in = '0;
    acc_in = 8'h00;
    bank_in = 1'b0;
    sp_in = 16'h0000;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (6) @(negedge clk);
    t_reset();
    arst_n = 1'b1;
    @(negedge clk);
    t_offset_call();
    t_offset_all();
    t_pc16_wrap();
    t_acc_call();
    t_refuse();
    final_report();
  end
endmodule
